/* design/rcs_defines.svh */
// Purpose: constants for the reset control and status flag block
// Assumes: 40 MHz MCLK (25 ns period)
// Notes: offsets are register indices; byte address is index times four
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

`define RCS_CLK_PS 25000
`define RCS_ADDR_FLAGS 8'h0f
`define RCS_ADDR_CPUCTL 8'h34
`define RCS_ADDR_PC_LO 8'h07
`define RCS_ADDR_PC_HI 8'h08
`define RCS_ADDR_LCD_LO 8'h09
`define RCS_ADDR_CAUSE 8'h40
`define RCS_ADDR_ARITH 8'h41
`define RCS_BIT_C 0
`define RCS_BIT_HALF 1
`define RCS_BIT_Z 2
`define RCS_BIT_WRAP 3
`define RCS_BIT_NONPOS 4
`define RCS_BIT_NONNEG 5
`define RCS_BIT_SLEEP_N 6
`define RCS_BIT_EXPIRY_N 7
`define RCS_BIT_SPEED 0
`define RCS_LCD_LO_RST 6'h00
`define RCS_PC_RST 8'h00
// Times in microseconds; all cycle counts round up
`define RCS_T_WUP_POR_US 500000
`define RCS_T_WUP_SLP_US 485000
`define RCS_T_CLKDET_US 1000
`define RCS_CYC(us) (((us) * 64'd1000000 + `RCS_CLK_PS - 1) / `RCS_CLK_PS)

`endif

/* design/rcs_pkg.sv */
// Purpose: types for the reset control and status flag block
// Assumes: nothing
// Notes: state codes are one-hot
package rcs_pkg;
    typedef enum logic [3:0] {
        RCS_ST_RESET = 4'h1,
        RCS_ST_CLKDET = 4'h2,
        RCS_ST_WARMUP = 4'h4,
        RCS_ST_RUN = 4'h8
    } rcs_state_t;
    typedef enum logic [1:0] {
        RCS_SRC_NONE = 2'h0,
        RCS_SRC_POR = 2'h1,
        RCS_SRC_PIN = 2'h2,
        RCS_SRC_WDT = 2'h3
    } rcs_src_t;
endpackage

/* design/rcs_top.sv */
// Purpose: merges reset sources, times warm-up, keeps reset cause and arithmetic flags
// Assumes: supply monitor and reset pin are asynchronous; core strobes are on MCLK
// Notes: registers are reached over a plain strobe port with read data one cycle later
//
// How it works
// (R1) System reset asserts while supply detector, watchdog expiry or reset pin is active.
// (R2) Reset holds while supply is low and re-asserts whenever supply drops again.
// (R3) A low on the reset pin of two cycles or more resets; a one-cycle low is filtered; pin idles high.
// (R4) Enabled watchdog expiry resets the chip; software kicks it before expiry.
// (R5) After power-on reset the CPU waits the power-on warm-up interval.
// (R6) After sleep wake-up the CPU waits the sleep warm-up interval.
// (R7) Slow clock presence is detected in about one millisecond at start-up.
// (R8) Flag bit 0 carry, inverse borrow on subtract; bit 1 half carry; bit 2 zero.
// (R9) Flag bit 3 set when the carry into bit 7 differs from the carry out of bit 7.
// (R10) Flag bit 4 shows signed result at most zero; binary arithmetic only.
// (R11) Flag bit 5 shows signed result at least zero; binary arithmetic only.
// (R12) Software fixes the accumulator sign bit using overflow with sign flags.
// (R13) Sleep-entry flag clears on sleep; set by kick, power-on or pin reset.
// (R14) Expiry flag clears on watchdog reset; set by kick, power-on, pin, sleep.
// (R15) Every reset restores register defaults except the expiry and sleep-entry flags and the upper two LCD address low bits.
// (R16) Flag pair encodes cause: 00 wdt in sleep, 01 wdt, 11 power or pin.
// (R17) Watchdog reset clears expiry flag, keeps sleep flag; power or pin sets both.
// (R18) Reset clears the watchdog timer and both program counter bytes.
// (R19) Reset clears lower six bits of the LCD address low register.
// (R20) Every reset reloads the speed select bit from the boot speed option.
// (R21) Oscillator is kept running or started during initialisation after reset.
// (R22) Reset asserts asynchronously on RESET_N and releases synchronously once the sequencer leaves its reset state.
//
// The address-and-strobe port is this design's own decision.
`include "rcs_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module rcs_top #(
    parameter logic [31:0] WUP_POR_CYC = 32'(`RCS_CYC(`RCS_T_WUP_POR_US)),
    parameter logic [31:0] WUP_SLP_CYC = 32'(`RCS_CYC(`RCS_T_WUP_SLP_US)),
    parameter logic [31:0] CLKDET_CYC = 32'(`RCS_CYC(`RCS_T_CLKDET_US))
) (
    input wire logic MCLK, // 40 MHz clock
    input wire logic RESET_N, // Asynchronous reset, active low
    input wire logic SUPPLY_OK, // Supply monitor, high above threshold
    input wire logic EXT_RESET_N_PIN, // Reset pin, low resets
    input wire logic WATCHDOG_EXPIRY, // Watchdog time-out level or pulse
    input wire logic WATCHDOG_ENABLE, // Watchdog enabled
    input wire logic BOOT_SPEED_OPTION, // Boot speed option, 1 fast
    input wire logic SLOW_CLK_TICK, // Slow clock sample, asynchronous
    input wire logic SLEEP_ENTER, // One-cycle pulse: sleep entered
    input wire logic SLEEP_WAKE, // One-cycle pulse: sleep woken
    input wire logic WATCHDOG_KICK_INSTR, // One-cycle pulse: watchdog kick
    input wire logic ALU_UPDATE, // One-cycle pulse: arithmetic result
    input wire logic ALU_IS_SUB, // Operation is a subtraction
    input wire logic ALU_IS_HEX, // Binary arithmetic, not decimal
    input wire logic [7:0] ALU_A, // First operand
    input wire logic [7:0] ALU_B, // Second operand
    input wire logic [7:0] ADDR, // Register index
    input wire logic [7:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output logic [7:0] RDATA, // Read data, cycle after read
    output logic SYS_RESET_N, // System reset to core, active low
    output logic CPU_HOLD, // CPU held for warm-up
    output logic OSC_ENABLE, // Oscillator run request
    output logic WATCHDOG_CLEAR, // Watchdog counter clear
    output logic [7:0] ARITH_AND_RESET_FLAGS, // Flag register
    output logic SPEED_SELECT_BIT // Speed select, 1 fast
);
    import rcs_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Bit 0 supply monitor, bit 1 reset pin, bit 2 slow clock
    localparam int NSYNC = 3;
    localparam logic [NSYNC-1:0] IDLE_LVL = 3'b010;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] agreed;
    logic sup_low;
    logic pin_low;
    logic tick_last;
    logic tick_seen;

    assign raw_in = {SLOW_CLK_TICK, EXT_RESET_N_PIN, SUPPLY_OK};

    // A change counts once stages two and three agree
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        logic [2:0] stage;
        logic keep;
        always_ff @(posedge MCLK or negedge RESET_N) begin
            if (!RESET_N) begin
                stage <= {3{IDLE_LVL[i]}};
                keep <= IDLE_LVL[i];
            end else begin
                stage <= {stage[1:0], raw_in[i]};
                if (stage[1] == stage[2]) begin
                    keep <= stage[2];
                end
            end
        end
        assign agreed[i] = keep;
    end

    assign sup_low = !agreed[0]; // R2
    assign pin_low = !agreed[1]; // R3

    // Any settled toggle of the slow clock counts as presence
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tick_last <= 1'b0;
            tick_seen <= 1'b0;
        end else begin
            tick_last <= agreed[2];
            tick_seen <= (agreed[2] != tick_last); // R7
        end
    end

    // ----------------------------------------------------------------
    // Reset sources and sequencer
    // ----------------------------------------------------------------
    logic wdt_fire;
    logic any_src;
    rcs_src_t last_src;
    rcs_state_t state;
    rcs_state_t next_state;
    logic [31:0] count;
    logic in_sleep;
    logic slp_warm;

    assign wdt_fire = WATCHDOG_EXPIRY && WATCHDOG_ENABLE; // R4
    assign any_src = sup_low || pin_low || wdt_fire; // R1

    always_comb begin
        next_state = state;
        case (state)
            RCS_ST_RESET: begin
                if (!any_src) begin
                    next_state = RCS_ST_CLKDET;
                end
            end
            RCS_ST_CLKDET: begin
                if (tick_seen || count >= CLKDET_CYC - 32'h1) begin
                    next_state = RCS_ST_WARMUP; // R7
                end
            end
            RCS_ST_WARMUP: begin
                if (count >= WUP_POR_CYC - 32'h1) begin
                    next_state = RCS_ST_RUN; // R5
                end
            end
            RCS_ST_RUN: begin
                next_state = RCS_ST_RUN;
            end
            default: next_state = RCS_ST_RESET;
        endcase
        if (any_src) begin
            next_state = RCS_ST_RESET; // R1 R2
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= RCS_ST_RESET;
            count <= 32'h0;
        end else begin
            state <= next_state;
            count <= (next_state != state) ? 32'h0 : count + 32'h1;
        end
    end

    // Sleep warm-up runs beside the main sequencer after the core wakes
    logic [31:0] slp_count;
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            in_sleep <= 1'b0;
            slp_warm <= 1'b0;
            slp_count <= 32'h0;
        end else if (state != RCS_ST_RUN) begin
            in_sleep <= 1'b0;
            slp_warm <= 1'b0;
            slp_count <= 32'h0;
        end else if (SLEEP_ENTER) begin
            in_sleep <= 1'b1;
        end else if (SLEEP_WAKE && in_sleep) begin
            in_sleep <= 1'b0;
            slp_warm <= 1'b1;
            slp_count <= 32'h0;
        end else if (slp_warm) begin
            slp_count <= slp_count + 32'h1;
            if (slp_count >= WUP_SLP_CYC - 32'h1) begin
                slp_warm <= 1'b0; // R6
            end
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            last_src <= RCS_SRC_POR;
        end else if (sup_low) begin
            last_src <= RCS_SRC_POR;
        end else if (pin_low) begin
            last_src <= RCS_SRC_PIN;
        end else if (wdt_fire) begin
            last_src <= RCS_SRC_WDT;
        end
    end

    // Reset output: async assert by reset input, sync release once the sequencer leaves reset
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SYS_RESET_N <= 1'b0;
        end else begin
            SYS_RESET_N <= !any_src && (state != RCS_ST_RESET); // R22
        end
    end

    // CPU held through power-on and sleep warm-up
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CPU_HOLD <= 1'b1;
        end else begin
            CPU_HOLD <= (next_state != RCS_ST_RUN) || slp_warm; // R5 R6
        end
    end

    // Oscillator stops only while the core sleeps
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            OSC_ENABLE <= 1'b1;
        end else begin
            OSC_ENABLE <= (state != RCS_ST_RUN) || !in_sleep; // R21
        end
    end

    // Watchdog counter cleared through reset and on each kick
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            WATCHDOG_CLEAR <= 1'b1;
        end else begin
            WATCHDOG_CLEAR <= (state == RCS_ST_RESET) || WATCHDOG_KICK_INSTR; // R18
        end
    end

    // ----------------------------------------------------------------
    // Arithmetic flags
    // ----------------------------------------------------------------
    logic [8:0] sum;
    logic [4:0] half;
    logic [7:0] opb;
    logic c6;
    logic [7:0] res;

    always_comb begin
        opb = ALU_IS_SUB ? ~ALU_B : ALU_B;
        sum = {1'b0, ALU_A} + {1'b0, opb} + {8'h00, ALU_IS_SUB};
        half = {1'b0, ALU_A[3:0]} + {1'b0, opb[3:0]} + {4'h0, ALU_IS_SUB};
        c6 = ALU_A[7] ^ opb[7] ^ sum[7];
        res = sum[7:0];
    end

    logic [5:0] arith;
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            arith <= 6'h00;
        end else if (state == RCS_ST_RESET) begin
            arith <= 6'h00; // R15
        end else if (ALU_UPDATE) begin
            arith[`RCS_BIT_C] <= sum[8]; // R8
            arith[`RCS_BIT_HALF] <= half[4]; // R8
            arith[`RCS_BIT_Z] <= (res == 8'h00); // R8
            arith[`RCS_BIT_WRAP] <= c6 ^ sum[8]; // R9
            if (ALU_IS_HEX) begin
                arith[`RCS_BIT_NONPOS] <= res[7] || (res == 8'h00); // R10
                arith[`RCS_BIT_NONNEG] <= !res[7]; // R11
            end
        end else if (WR && ADDR == `RCS_ADDR_FLAGS) begin
            arith <= WDATA[5:0];
        end
    end

    // ----------------------------------------------------------------
    // Cause flags, kept across reset
    // ----------------------------------------------------------------
    logic expiry_n;
    logic sleep_n;
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            expiry_n <= 1'b1;
            sleep_n <= 1'b1;
        end else if (sup_low || pin_low) begin
            expiry_n <= 1'b1; // R14 R16 R17
            sleep_n <= 1'b1; // R13 R17
        end else if (wdt_fire) begin
            expiry_n <= 1'b0; // R14 R17
            sleep_n <= sleep_n; // R16
        end else if (WATCHDOG_KICK_INSTR) begin
            expiry_n <= 1'b1; // R14
            sleep_n <= 1'b1; // R13
        end else if (SLEEP_ENTER && state == RCS_ST_RUN) begin
            expiry_n <= 1'b1; // R14
            sleep_n <= 1'b0; // R13
        end
    end

    // ----------------------------------------------------------------
    // Reset-loaded core registers
    // ----------------------------------------------------------------
    logic [7:0] pc_lo;
    logic [7:0] pc_hi;
    logic [5:0] lcd_lo;
    logic [1:0] lcd_hi;
    logic speed;
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pc_lo <= `RCS_PC_RST;
            pc_hi <= `RCS_PC_RST;
        end else if (state == RCS_ST_RESET) begin
            pc_lo <= `RCS_PC_RST; // R18
            pc_hi <= `RCS_PC_RST; // R18
        end else if (WR && ADDR == `RCS_ADDR_PC_LO) begin
            pc_lo <= WDATA;
        end else if (WR && ADDR == `RCS_ADDR_PC_HI) begin
            pc_hi <= WDATA;
        end
    end

    // Upper two bits keep their old value through reset
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lcd_lo <= `RCS_LCD_LO_RST;
            lcd_hi <= 2'h0;
        end else if (state == RCS_ST_RESET) begin
            lcd_lo <= `RCS_LCD_LO_RST; // R19
        end else if (WR && ADDR == `RCS_ADDR_LCD_LO) begin
            lcd_lo <= WDATA[5:0];
            lcd_hi <= WDATA[7:6];
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            speed <= 1'b0;
        end else if (state == RCS_ST_RESET) begin
            speed <= BOOT_SPEED_OPTION; // R20
        end else if (WR && ADDR == `RCS_ADDR_CPUCTL) begin
            speed <= WDATA[`RCS_BIT_SPEED];
        end
    end

    // ----------------------------------------------------------------
    // Outputs and read port
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ARITH_AND_RESET_FLAGS <= 8'hc0;
            SPEED_SELECT_BIT <= 1'b0;
            RDATA <= 8'h00;
        end else begin
            ARITH_AND_RESET_FLAGS <= {expiry_n, sleep_n, arith};
            SPEED_SELECT_BIT <= speed;
            if (RD) begin
                case (ADDR)
                    `RCS_ADDR_FLAGS: RDATA <= {expiry_n, sleep_n, arith};
                    `RCS_ADDR_CPUCTL: RDATA <= {7'h00, speed};
                    `RCS_ADDR_PC_LO: RDATA <= pc_lo;
                    `RCS_ADDR_PC_HI: RDATA <= pc_hi;
                    `RCS_ADDR_LCD_LO: RDATA <= {lcd_hi, lcd_lo};
                    `RCS_ADDR_CAUSE: RDATA <= {state, 2'h0, last_src};
                    default: RDATA <= 8'h00;
                endcase
            end else begin
                RDATA <= 8'h00;
            end
        end
    end

endmodule
`default_nettype wire

/* bench/rcs_top_properties.sv */
// Purpose: port-level assertions for rcs_top
// Assumes: one MCLK domain, asynchronous RESET_N
// Notes: bound to the design from the bench top file
`timescale 1ns/100ps
`default_nettype none
module rcs_top_properties #(
    parameter logic [31:0] WUP_POR_CYC = 32'd20,
    parameter logic [31:0] WUP_SLP_CYC = 32'd15,
    parameter logic [31:0] CLKDET_CYC = 32'd10
) (
    input wire logic MCLK, // Clock
    input wire logic RESET_N, // Reset
    input wire logic SUPPLY_OK, // Supply monitor
    input wire logic EXT_RESET_N_PIN, // Reset pin
    input wire logic WATCHDOG_EXPIRY, // Expiry
    input wire logic WATCHDOG_ENABLE, // Watchdog on
    input wire logic BOOT_SPEED_OPTION, // Boot speed
    input wire logic SLEEP_ENTER, // Sleep entry
    input wire logic WATCHDOG_KICK_INSTR, // Kick
    input wire logic SYS_RESET_N, // System reset
    input wire logic CPU_HOLD, // Warm-up hold
    input wire logic OSC_ENABLE, // Oscillator run
    input wire logic WATCHDOG_CLEAR, // Watchdog clear
    input wire logic [7:0] ARITH_AND_RESET_FLAGS, // Flags
    input wire logic SPEED_SELECT_BIT // Speed bit
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    logic wdf;
    logic [31:0] hold_cnt;
    assign wdf = WATCHDOG_EXPIRY && WATCHDOG_ENABLE;
    // Length of the current warm-up seen with system reset released
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) hold_cnt <= '0;
        else hold_cnt <= (CPU_HOLD && SYS_RESET_N) ? hold_cnt + 32'd1 : '0;
    end
    chk_wdt_reset: assert property (wdf |=> !SYS_RESET_N)
        else $error("watchdog expiry gave no reset");
    chk_wdt_flags: assert property (wdf && SYS_RESET_N && SUPPLY_OK && EXT_RESET_N_PIN |-> ##2
        !ARITH_AND_RESET_FLAGS[7] && ARITH_AND_RESET_FLAGS[6] == $past(ARITH_AND_RESET_FLAGS[6], 2))
        else $error("watchdog reset flags wrong");
    chk_sleep_flags: assert property (SLEEP_ENTER && SYS_RESET_N && !CPU_HOLD && !wdf
        && !WATCHDOG_KICK_INSTR |-> ##2 ARITH_AND_RESET_FLAGS[7:6] == 2'b10 && !OSC_ENABLE)
        else $error("sleep entry flags wrong");
    chk_kick_flags: assert property (WATCHDOG_KICK_INSTR && SYS_RESET_N && !wdf
        |=> WATCHDOG_CLEAR ##1 ARITH_AND_RESET_FLAGS[7:6] == 2'b11)
        else $error("kick did not set flags");
    chk_rst_clear: assert property ($fell(SYS_RESET_N) |-> ##[0:2] WATCHDOG_CLEAR)
        else $error("watchdog not cleared in reset");
    chk_rst_hold: assert property (!SYS_RESET_N [*3] |-> CPU_HOLD && OSC_ENABLE)
        else $error("hold or oscillator low in reset");
    chk_supply_low: assert property (!SUPPLY_OK [*7] |-> !SYS_RESET_N)
        else $error("low supply not in reset");
    chk_pin_low: assert property (!EXT_RESET_N_PIN [*7] |->
        !SYS_RESET_N && ARITH_AND_RESET_FLAGS[7:6] == 2'b11)
        else $error("pin low not in reset");
    chk_speed_load: assert property (!SYS_RESET_N [*3] |-> SPEED_SELECT_BIT == $past(BOOT_SPEED_OPTION))
        else $error("speed bit not reloaded");
    chk_hold_max: assert property (CPU_HOLD && SYS_RESET_N |->
        hold_cnt <= CLKDET_CYC + WUP_POR_CYC + 32'd4)
        else $error("warm-up too long");
    chk_hold_min: assert property ($fell(CPU_HOLD) && SYS_RESET_N |-> hold_cnt + 32'd2 >= WUP_SLP_CYC)
        else $error("warm-up too short");
endmodule
`default_nettype wire

/* bench/rcs_partner.sv */
// Purpose: supply monitor, reset pin and slow clock beside rcs_top
// Assumes: tasks are called just after a rising MCLK edge
// Notes: the slow clock stands still while slow_run is low
`timescale 1ns/100ps
`default_nettype none
module rcs_partner #(
    parameter int TICK_HALF = 3
) (
    input wire logic MCLK, // Clock
    output logic SUPPLY_OK, // Supply above threshold
    output logic EXT_RESET_N_PIN, // Reset pin
    output logic SLOW_CLK_TICK // Slow clock
);
    logic slow_run = 1'b1;
    int ph = 0;
    initial begin
        SUPPLY_OK = 1'b0;
        EXT_RESET_N_PIN = 1'b1;
        SLOW_CLK_TICK = 1'b0;
        repeat (12) @(posedge MCLK);
        SUPPLY_OK <= 1'b1;
    end
    always @(posedge MCLK) begin
        ph <= (ph == TICK_HALF) ? 0 : ph + 1;
        if (slow_run && ph == TICK_HALF) begin
            SLOW_CLK_TICK <= !SLOW_CLK_TICK;
        end
    end
    task automatic supply_dip(input int n);
        SUPPLY_OK <= 1'b0;
        repeat (n) @(posedge MCLK);
        SUPPLY_OK <= 1'b1;
    endtask
    task automatic pin_low(input int n);
        EXT_RESET_N_PIN <= 1'b0;
        repeat (n) @(posedge MCLK);
        EXT_RESET_N_PIN <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* bench/tb_rcs_top.sv */
// Purpose: self-checking bench for rcs_top
// Assumes: warm-up counts shortened to 20, 15 and 10 cycles
// Notes: the partner drives supply, reset pin and slow clock
`timescale 1ns/100ps
`default_nettype none
module tb_rcs_top;
    localparam logic [31:0] SLP = 32'd15;
    logic MCLK = '0, RESET_N = '0, WATCHDOG_EXPIRY = '0, WATCHDOG_ENABLE = '0;
    logic BOOT_SPEED_OPTION = '0, SLEEP_ENTER = '0, SLEEP_WAKE = '0, WATCHDOG_KICK_INSTR = '0;
    logic ALU_UPDATE = '0, ALU_IS_SUB = '0, ALU_IS_HEX = '0, WR = '0, RD = '0;
    logic [7:0] ALU_A = '0, ALU_B = '0, ADDR = '0, WDATA = '0, RDATA, ARITH_AND_RESET_FLAGS;
    logic SUPPLY_OK, EXT_RESET_N_PIN, SLOW_CLK_TICK, SYS_RESET_N, CPU_HOLD;
    logic OSC_ENABLE, WATCHDOG_CLEAR, SPEED_SELECT_BIT;
    logic [7:0] opa [4] = '{8'h60, 8'h50, 8'hff, 8'h05};
    logic [7:0] opb [4] = '{8'h70, 8'h90, 8'h01, 8'h05};
    logic ops [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    int fail_count = 0, checked = 0;
    always #12.5 MCLK = !MCLK;
    rcs_top #(.WUP_POR_CYC(32'd20), .WUP_SLP_CYC(SLP), .CLKDET_CYC(32'd10)) uut (.*);
    rcs_partner mate (.*);
    task automatic give_verdict;
        if (fail_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask
    task automatic rd(input logic [7:0] a, m, exp, input string nm);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 cmp(nm, exp, RDATA & m);
        @(posedge MCLK);
    endtask
    task automatic wr(input logic [7:0] a, d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
        @(posedge MCLK);
    endtask
    // Mask bits: expiry, sleep entry, wake, kick
    task automatic pulse(input logic [3:0] m);
        {WATCHDOG_EXPIRY, SLEEP_ENTER, SLEEP_WAKE, WATCHDOG_KICK_INSTR} <= m;
        @(posedge MCLK);
        {WATCHDOG_EXPIRY, SLEEP_ENTER, SLEEP_WAKE, WATCHDOG_KICK_INSTR} <= 4'h0;
        @(posedge MCLK);
    endtask
    task automatic alu(input logic [7:0] a, b, input logic s, h);
        {ALU_A, ALU_B, ALU_IS_SUB, ALU_IS_HEX, ALU_UPDATE} <= {a, b, s, h, 1'b1};
        @(posedge MCLK);
        ALU_UPDATE <= 1'b0;
        @(posedge MCLK);
    endtask
    task automatic await(input logic r, h);
        repeat (300) begin
            #1;
            if (SYS_RESET_N === r && CPU_HOLD === h) begin
                @(posedge MCLK);
                return;
            end
            @(posedge MCLK);
        end
        cmp("wait_state", {6'h0, r, h}, {6'h0, SYS_RESET_N, CPU_HOLD});
        give_verdict;
    endtask
    task automatic settle;
        await(1'b0, 1'b1);
        await(1'b1, 1'b0);
    endtask
    function automatic logic [7:0] fl(input logic [7:0] a, b, input logic s);
        logic [7:0] bb;
        logic [8:0] r;
        logic [4:0] h;
        logic [7:0] c7;
        bb = s ? ~b : b;
        r = {1'b0, a} + {1'b0, bb} + {8'h0, s};
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, s};
        c7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h0, s};
        return {2'b00, !r[7], r[7] | (r[7:0] == 8'h0), c7[7] ^ r[8], r[7:0] == 8'h0, h[4], r[8]};
    endfunction
    // --------------------------------
    // Main sequence
    // --------------------------------
    initial begin
        int n;
        repeat (10) @(posedge MCLK);
        RESET_N <= 1'b1;
        settle;
        rd(8'h0f, 8'hff, 8'hc0, "flags");
        rd(8'h34, 8'h01, 8'h00, "speed");
        cmp("osc", 8'h01, {7'h0, OSC_ENABLE});
        wr(8'h07, 8'h5a);
        wr(8'h09, 8'h3f);
        wr(8'h0f, 8'h3f);
        wr(8'h41, 8'ha5);
        rd(8'h07, 8'hff, 8'h5a, "pc_low");
        rd(8'h0f, 8'hff, 8'hff, "flags");
        rd(8'h41, 8'hff, 8'h00, "unmapped");
        BOOT_SPEED_OPTION <= 1'b1;
        // Shortest pulse that two agreeing synchroniser stages still see
        mate.pin_low(2);
        settle;
        rd(8'h07, 8'hff, 8'h00, "pc_low");
        rd(8'h09, 8'h3f, 8'h00, "lcd_low");
        rd(8'h0f, 8'hff, 8'hc0, "flags");
        rd(8'h34, 8'h01, 8'h01, "speed");
        mate.pin_low(8);
        settle;
        pulse(4'h8);
        repeat (8) @(posedge MCLK);
        cmp("sys_reset_n", 8'h01, {7'h0, SYS_RESET_N});
        WATCHDOG_ENABLE <= 1'b1;
        pulse(4'h8);
        settle;
        rd(8'h0f, 8'hff, 8'h40, "flags");
        pulse(4'h1);
        rd(8'h0f, 8'hff, 8'hc0, "flags");
        pulse(4'h4);
        rd(8'h0f, 8'hff, 8'h80, "flags");
        pulse(4'h2);
        n = 0;
        repeat (40) begin
            #1 n += int'(CPU_HOLD === 1'b1);
            @(posedge MCLK);
        end
        cmp("wake_hold", 8'h01, {7'h0, n + 2 >= SLP && n <= SLP + 1});
        pulse(4'h4);
        pulse(4'h8);
        settle;
        rd(8'h0f, 8'hff, 8'h00, "flags");
        mate.slow_run = 1'b0;
        mate.supply_dip(10);
        settle;
        mate.slow_run = 1'b1;
        rd(8'h0f, 8'hff, 8'hc0, "flags");
        wr(8'h0f, 8'h30);
        alu(8'h12, 8'h34, 1'b0, 1'b0);
        rd(8'h0f, 8'h30, 8'h30, "signed_flags");
        for (int i = 0; i < 4; i++) begin
            alu(opa[i], opb[i], ops[i], 1'b1);
            rd(8'h0f, 8'h3f, fl(opa[i], opb[i], ops[i]), "arith_flags");
        end
        give_verdict;
    end
endmodule
bind rcs_top rcs_top_properties #(.WUP_POR_CYC(WUP_POR_CYC), .WUP_SLP_CYC(WUP_SLP_CYC),
    .CLKDET_CYC(CLKDET_CYC)) chk (.*);
`default_nettype wire
